// *** src/rx_desc_engine.sv ***
// receive descriptor split classifier, fetch scheduler and write-back packer
`timescale 1ns/1ps
module rx_desc_engine
	import rx_desc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        desc_used,
	input  wire logic        timer_expired,
	input  wire logic        other_pending,
	input  wire logic        host_done,
	output host_req_t        host_req,
	output logic             rx_interrupt
);

	// ==========================================================
	// apb decode
	logic        wr_en;
	logic        rd_en;
	logic        hit_ctrl;
	logic        hit_thresh;
	logic        hit_delay;
	logic        hit_tail;
	logic        hit_status;
	logic        hit_pin;
	logic        hit_pout;
	logic        hit_rlen;
	logic        mapped;
	assign hit_ctrl   = (paddr == ctrl_off);
	assign hit_thresh = (paddr == thresh_off);
	assign hit_delay  = (paddr == delay_off);
	assign hit_tail   = (paddr == tail_off);
	assign hit_status = (paddr == status_off);
	assign hit_pin    = (paddr == parse_in_off);
	assign hit_pout   = (paddr == parse_out_off);
	assign hit_rlen   = (paddr == ring_len_off);
	assign mapped     = hit_ctrl | hit_thresh | hit_delay | hit_tail | hit_status
		| hit_pin | hit_pout | hit_rlen;
	// access phase completes in one cycle; pready is registered so it rises on the second
	assign wr_en = psel & penable & pwrite & pready;
	assign rd_en = psel & ~penable & ~pwrite;

	// ==========================================================
	// software state
	logic [31:0] ctrl_reg;
	logic [31:0] thresh_reg;
	logic [ptr_w-1:0] tail_reg;
	logic [ptr_w-1:0] ring_len_reg;
	logic [31:0] parse_in_reg;
	logic        flush_reg;
	parse_info_t pinfo;
	logic [5:0]  prefetch_threshold;
	logic [5:0]  host_avail_threshold;
	logic [5:0]  writeback_threshold;
	logic        extended_status_enable;
	logic        parse_enable;
	logic [1:0]  descriptor_type;
	logic        split_mode;
	assign prefetch_threshold     = thresh_reg[5:0];
	assign host_avail_threshold   = thresh_reg[13:8];
	assign writeback_threshold    = thresh_reg[21:16];
	assign extended_status_enable = ctrl_reg[ext_status_bit];
	assign parse_enable           = ctrl_reg[parse_en_bit];
	assign descriptor_type        = ctrl_reg[dtyp_lsb+1:dtyp_lsb];
	assign split_mode = extended_status_enable & (descriptor_type == dtyp_split);

	// parse input word: frag flags and the selected layer end byte offsets; type comes from ctrl_reg[11:8]
	logic [9:0] end_l3;
	logic [9:0] end_l4;
	logic [9:0] end_l5;
	assign end_l3 = parse_in_reg[9:0];
	assign end_l4 = parse_in_reg[19:10];
	assign end_l5 = parse_in_reg[29:20];
	assign pinfo  = '{v4_frag: parse_in_reg[30], v6_frag: parse_in_reg[31],
		l3_end: end_l3, l4_end: end_l4, l5_end: end_l5,
		v6_frag_end: end_l3, ptype: ctrl_reg[11:8]};

	// ==========================================================
	// split classification
	logic       frag_any;
	logic       split_hit;
	logic [9:0] split_at;
	assign frag_any = pinfo.v4_frag | pinfo.v6_frag;
	always_comb begin
		split_hit = 1'b0;
		split_at  = pinfo.l3_end;
		unique case (pinfo.ptype)
			// single-stack types look only at their own header's fragment flag
			pt_v4: begin
				split_hit = pinfo.v4_frag;
			end
			pt_v6: begin
				split_hit = pinfo.v6_frag;
			end
			pt_v4_l4: begin
				split_hit = 1'b1;
				split_at  = pinfo.v4_frag ? pinfo.l3_end : pinfo.l4_end;
			end
			pt_v4v6: begin
				split_hit = frag_any;
			end
			pt_v4v6_l4: begin
				split_hit = 1'b1;
				split_at  = frag_any ? pinfo.l3_end : pinfo.l4_end;
			end
			pt_v6_l4: begin
				split_hit = 1'b1;
				split_at  = pinfo.v6_frag ? pinfo.l3_end : pinfo.l4_end;
			end
			pt_v4_iscsi, pt_v4_nfs: begin
				split_hit = 1'b1;
				split_at  = pinfo.v4_frag ? pinfo.l3_end : pinfo.l5_end;
			end
			pt_v4v6_iscsi, pt_v4v6_nfs: begin
				split_hit = 1'b1;
				split_at  = frag_any ? pinfo.l3_end : pinfo.l5_end;
			end
			pt_v6_iscsi, pt_v6_nfs: begin
				split_hit = 1'b1;
				split_at  = pinfo.v6_frag ? pinfo.v6_frag_end : pinfo.l5_end;
			end
			default: begin
				split_hit = 1'b0;
			end
		endcase
		if (pinfo.v6_frag && split_hit && split_at == pinfo.l3_end) begin
			split_at = pinfo.v6_frag_end;
		end
	end

	// buffer 0 receives header_length bytes; no split means linear posting from buffer 0
	split_result_t result_reg;
	split_result_t result_next;
	always_comb begin
		result_next               = '0;
		result_next.ptype         = parse_enable ? pinfo.ptype : pt_l2;
		if (split_mode && parse_enable && split_hit) begin
			result_next.split_done    = 1'b1;
			result_next.header_length = split_at;
		end
		if (!split_mode) begin
			result_next.header_length = 10'h000;
		end
	end

	// ==========================================================
	// descriptor ring pointers and counts
	logic [ptr_w-1:0] fetch_ptr_reg;
	logic [ptr_w-1:0] wb_ptr_reg;
	logic [cnt_w-1:0] onchip_reg;
	logic [cnt_w-1:0] used_reg;
	logic [ptr_w-1:0] host_avail;
	logic [cnt_w-1:0] space;
	logic [cnt_w-1:0] to_line;
	logic [cnt_w-1:0] fetch_cnt;
	logic [cnt_w-1:0] host_cap;
	logic             ring_end;
	logic             want_fetch;
	logic             want_wb;
	assign host_avail = (tail_reg >= fetch_ptr_reg) ? (tail_reg - fetch_ptr_reg)
		: (ptr_w'(ring_len_reg - fetch_ptr_reg) + tail_reg);
	assign space      = store_depth - onchip_reg;
	assign to_line    = line_descs - cnt_w'(fetch_ptr_reg[1:0]);
	assign host_cap   = (host_avail > ptr_w'(store_depth)) ? store_depth : host_avail[cnt_w-1:0];
	// fetch up to free space; trim so the following burst lands on a line boundary
	always_comb begin
		fetch_cnt = (host_cap < space) ? host_cap : space;
		if (host_cap > space && space > to_line) begin
			fetch_cnt = space - ((space - to_line) & (line_descs - 7'h01));
		end
	end
	assign ring_end   = desc_used && (wb_ptr_reg + ptr_w'(used_reg) == ring_len_reg - 8'h01);
	assign want_fetch = (host_avail != '0) && (space != '0) && (
		(onchip_reg == '0)
		|| ((onchip_reg <= cnt_w'(prefetch_threshold)) && !other_pending
			&& (host_avail >= ptr_w'(host_avail_threshold))));
	// write-back triggers, latched until served
	logic wb_pending_reg;
	logic wb_fire;
	assign wb_fire = (writeback_threshold != '0 && used_reg >= cnt_w'(writeback_threshold))
		|| ring_end || timer_expired || flush_reg;
	assign want_wb = (wb_fire || wb_pending_reg) && (used_reg != '0 || desc_used);

	// ==========================================================
	// host transfer sequencer
	typedef enum logic [1:0] {idle_st, fetch_st, wb_st} seq_state_t;
	seq_state_t state_reg;
	seq_state_t state_next;
	logic       int_pending_reg;
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			idle_st: begin
				if (want_wb) begin
					state_next = wb_st;
				end else if (want_fetch) begin
					state_next = fetch_st;
				end
			end
			fetch_st, wb_st: begin
				if (host_done) begin
					state_next = idle_st;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg       <= idle_st;
			host_req        <= '0;
			fetch_ptr_reg   <= '0;
			wb_ptr_reg      <= '0;
			onchip_reg      <= '0;
			used_reg        <= '0;
			wb_pending_reg  <= 1'b0;
			int_pending_reg <= 1'b0;
			rx_interrupt    <= 1'b0;
		end else begin
			state_reg    <= state_next;
			rx_interrupt <= 1'b0;
			// a finished write-back keeps only ring-end, timer and flush triggers of its own last cycle
			if (state_reg == wb_st && host_done) begin
				wb_pending_reg <= ring_end || timer_expired || flush_reg;
			end else if (wb_fire) begin
				wb_pending_reg <= 1'b1;
			end else if (state_reg == idle_st && used_reg == '0) begin
				wb_pending_reg <= 1'b0;
			end
			if (timer_expired || flush_reg) begin
				int_pending_reg <= 1'b1;
			end
			if (state_reg == idle_st && state_next == fetch_st) begin
				host_req <= '{req: 1'b1, write: 1'b0, index: fetch_ptr_reg, count: fetch_cnt};
			end else if (state_reg == idle_st && state_next == wb_st) begin
				host_req <= '{req: 1'b1, write: 1'b1, index: wb_ptr_reg,
					count: used_reg + cnt_w'(desc_used)};
			end else if (host_done) begin
				host_req.req <= 1'b0;
			end
			if (state_reg == fetch_st && host_done) begin
				onchip_reg    <= onchip_reg + host_req.count - cnt_w'(desc_used);
				fetch_ptr_reg <= ptr_w'((fetch_ptr_reg + ptr_w'(host_req.count))
					% ring_len_reg);
			end else if (desc_used && onchip_reg != '0) begin
				onchip_reg <= onchip_reg - 7'h01;
			end
			if (state_reg == wb_st && host_done) begin
				// descriptors used while the burst ran stay counted for the next one
				used_reg       <= used_reg + cnt_w'(desc_used) - host_req.count;
				wb_ptr_reg     <= ptr_w'((wb_ptr_reg + ptr_w'(host_req.count))
					% ring_len_reg);
				if (int_pending_reg) begin
					rx_interrupt    <= 1'b1;
					int_pending_reg <= timer_expired || flush_reg;
				end
			end else if (desc_used && state_reg != wb_st) begin
				used_reg <= used_reg + 7'h01;
			end else if (desc_used) begin
				used_reg <= used_reg + 7'h01;
			end
			if (int_pending_reg && state_reg == idle_st && !want_wb && used_reg == '0) begin
				rx_interrupt    <= 1'b1;
				int_pending_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// apb registers
	logic [31:0] rd_mux;
	assign rd_mux = hit_ctrl   ? ctrl_reg
		: hit_thresh ? thresh_reg
		: hit_tail   ? {24'h000000, tail_reg}
		: hit_status ? {state_reg, 7'h00, used_reg, 1'b0, onchip_reg, fetch_ptr_reg}
		: hit_pin    ? parse_in_reg
		: hit_pout   ? {16'h0000, result_reg.split_done, 1'b0, result_reg.ptype,
			result_reg.header_length}
		: hit_rlen   ? {24'h000000, ring_len_reg}
		: 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg     <= '0;
			thresh_reg   <= {26'h0000000, thresh_rst};
			tail_reg     <= '0;
			ring_len_reg <= ring_len_rst;
			parse_in_reg <= '0;
			flush_reg    <= 1'b0;
			result_reg   <= '0;
			prdata       <= '0;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
		end else begin
			pready     <= psel & ~penable;
			pslverr    <= psel & ~penable & ~mapped;
			flush_reg  <= 1'b0;
			result_reg <= result_next;
			if (rd_en) begin
				prdata <= rd_mux;
			end
			if (wr_en && mapped) begin
				if (hit_ctrl) begin
					ctrl_reg <= pwdata;
				end
				if (hit_thresh) begin
					thresh_reg <= pwdata;
				end
				if (hit_delay) begin
					flush_reg <= pwdata[flush_bit];
				end
				if (hit_tail) begin
					tail_reg <= pwdata[ptr_w-1:0];
				end
				if (hit_pin) begin
					parse_in_reg <= pwdata;
				end
				if (hit_rlen) begin
					ring_len_reg <= pwdata[ptr_w-1:0];
				end
			end
		end
	end

endmodule

// *** src/rx_desc_pkg.sv ***
// package of constants and carriers for the receive descriptor split, fetch and write-back block
// Functional notes
// - header_length is a 10-bit count of bytes parsed as header.
// - when splitting, the first header_length bytes go to buffer 0.
// - header_length is meaningful only in split packet mode, else zero.
// - packet types not eligible for split are posted linearly across buffers.
// - types 1h and 5h split after layer 3 only when fragmented.
// - type 2h splits after layer 4 unfragmented, else behaves as type 1h.
// - type 3h splits after layer 3 when IPv4 or IPv6 shows fragmentation.
// - types 4h and 6h split after layer 4 unfragmented, else as 3h or 5h.
// - types 7h and 8h split after layer 5 unfragmented, else as 1h.
// - types 9h and Ah split after layer 5 unfragmented, else as 3h.
// - types Bh and Ch split after layer 5 without fragment header, else as 5h.
// - a fragmented IPv6 header ends at its fragment extension header.
// - no parsing offload gives packet type zero; split mode keeps type valid.
// - up to 64 descriptors held on chip; fetch a cache line per burst (the code fetches up to the free space, up to 64 per burst).
// - empty store fetches as soon as software makes any descriptor available.
// - prefetch at threshold only with enough host descriptors and nothing pending.
// - partial fetch allowed when it leaves the next fetch cache-line aligned.
// - never read a descriptor at or beyond the tail pointer.
// - used 16-byte descriptors write back on threshold, ring end, timer, flush.
// - write-back threshold triggers regardless of cache-line alignment.
// - on timer expiry all used descriptors are written before the interrupt; expiry mid write-back interrupts at its end, ones used in it unwritten.
// - writing packet_delay_timer with top bit set forces a flush.
// - split format only with extended_status_enable and descriptor_type 01b.
// - header_split_done in bit 15 of header status when header was split.
package rx_desc_pkg;

	// ==========================================================
	// register map (byte offsets)
	localparam logic [7:0] ctrl_off        = 8'h00;
	localparam logic [7:0] thresh_off      = 8'h04;
	localparam logic [7:0] delay_off       = 8'h08;
	localparam logic [7:0] tail_off        = 8'h0c;
	localparam logic [7:0] status_off      = 8'h10;
	localparam logic [7:0] parse_in_off    = 8'h14;
	localparam logic [7:0] parse_out_off   = 8'h18;
	localparam logic [7:0] ring_len_off    = 8'h1c;

	// ==========================================================
	// field positions and widths
	localparam int         ext_status_bit  = 0;
	localparam int         parse_en_bit    = 1;
	localparam int         dtyp_lsb        = 2;
	localparam int         flush_bit       = 31;
	localparam int         split_done_bit  = 15;
	localparam int         ptr_w           = 8;
	localparam int         cnt_w           = 7;
	localparam logic [1:0] dtyp_split      = 2'h1;
	localparam logic [6:0] store_depth     = 7'h40;
	localparam logic [6:0] line_descs      = 7'h04;
	localparam logic [7:0] ring_len_rst    = 8'h80;
	localparam logic [5:0] thresh_rst      = 6'h00;

	// packet type codes
	localparam logic [3:0] pt_l2           = 4'h0;
	localparam logic [3:0] pt_v4           = 4'h1;
	localparam logic [3:0] pt_v4_l4        = 4'h2;
	localparam logic [3:0] pt_v4v6         = 4'h3;
	localparam logic [3:0] pt_v4v6_l4      = 4'h4;
	localparam logic [3:0] pt_v6           = 4'h5;
	localparam logic [3:0] pt_v6_l4        = 4'h6;
	localparam logic [3:0] pt_v4_iscsi     = 4'h7;
	localparam logic [3:0] pt_v4_nfs       = 4'h8;
	localparam logic [3:0] pt_v4v6_iscsi   = 4'h9;
	localparam logic [3:0] pt_v4v6_nfs     = 4'ha;
	localparam logic [3:0] pt_v6_iscsi     = 4'hb;
	localparam logic [3:0] pt_v6_nfs       = 4'hc;

	typedef struct packed {
		logic       v4_frag;
		logic       v6_frag;
		logic [9:0] l3_end;
		logic [9:0] l4_end;
		logic [9:0] l5_end;
		logic [9:0] v6_frag_end;
		logic [3:0] ptype;
	} parse_info_t;

	typedef struct packed {
		logic       split_done;
		logic [3:0] ptype;
		logic [9:0] header_length;
	} split_result_t;

	typedef struct packed {
		logic           req;
		logic           write;
		logic [7:0]     index;
		logic [cnt_w-1:0] count;
	} host_req_t;

endpackage

// *** testbench/host_mem.sv ***
// host memory model answering descriptor fetches and write-backs
`timescale 1ns/1ps
module host_mem
	import rx_desc_pkg::*;
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire host_req_t  host_req,
	input wire logic [3:0] delay,
	output logic           host_done,
	output host_req_t      last_wb,
	output logic [7:0]     fetch_end
);
	logic [3:0] wait_cnt;
	// ==========================================================
	// answer after a programmable latency so slow memory is exercised
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_done <= 1'b0;
			wait_cnt  <= 4'h0;
			last_wb   <= '0;
			fetch_end <= 8'h00;
		end else if (host_done) begin
			host_done <= 1'b0;
			wait_cnt  <= 4'h0;
		end else if (host_req.req) begin
			if (wait_cnt == delay) begin
				host_done <= 1'b1;
				if (host_req.write)
					last_wb <= host_req;
				else
					fetch_end <= host_req.index + 8'(host_req.count);
			end else
				wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule

// *** testbench/rx_desc_props.sv ***
// port-level checker for the receive descriptor engine
`timescale 1ns/1ps
module rx_desc_props
	import rx_desc_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        desc_used,
	input wire logic        timer_expired,
	input wire logic        other_pending,
	input wire logic        host_done,
	input wire host_req_t   host_req,
	input wire logic        rx_interrupt
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// register bus
	a_ready_access: assert property (psel && !penable |=> pready)
		else $error("access not answered in first cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	// ==========================================================
	// host requests
	a_req_hold: assert property (host_req.req && !host_done |=> $stable(host_req))
		else $error("request changed before done");
	a_req_gap: assert property (host_done |=> !host_req.req)
		else $error("request not released after done");
	a_fetch_size: assert property ($rose(host_req.req) && !host_req.write |->
		host_req.count inside {[1:64]})
		else $error("fetch count out of range");
	a_wb_size: assert property (host_req.req && host_req.write |-> host_req.count != 7'h0)
		else $error("empty write-back");
	// ==========================================================
	// interrupt
	a_irq_pulse: assert property (rx_interrupt |=> !rx_interrupt)
		else $error("interrupt longer than one cycle");
	a_irq_after_wb: assert property (rx_interrupt |-> !(host_req.req && host_req.write))
		else $error("interrupt before write-back finished");
endmodule

bind rx_desc_engine rx_desc_props props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .desc_used(desc_used), .timer_expired(timer_expired),
	.other_pending(other_pending), .host_done(host_done), .host_req(host_req),
	.rx_interrupt(rx_interrupt));

// *** testbench/tb.sv ***
// self-checking bench for the receive descriptor engine
`timescale 1ns/1ps
module tb
	import rx_desc_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic        desc_used, timer_expired, other_pending, host_done, rx_interrupt;
	logic [7:0]  paddr, fetch_end;
	logic [31:0] pwdata, prdata, r;
	logic [3:0]  delay;
	host_req_t   host_req, last_wb;
	int          miscompares, num_checks, cycles, irq_cnt;
	localparam logic [9:0] l3 = 10'h022, l4 = 10'h036, l5 = 10'h066;

	rx_desc_engine DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .desc_used(desc_used), .timer_expired(timer_expired),
		.other_pending(other_pending), .host_done(host_done), .host_req(host_req),
		.rx_interrupt(rx_interrupt));
	host_mem mem (.pclk(pclk), .presetn(presetn), .host_req(host_req), .delay(delay),
		.host_done(host_done), .last_wb(last_wb), .fetch_end(fetch_end));

	// ==========================================================
	// common tasks
	task automatic finish_test();
		if (miscompares == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// host side counts as idle only after a quiet stretch, so late requests are caught
	task automatic wait_idle();
		int q = 0;
		while (q < 8) begin
			@(posedge pclk);
			q = host_req.req ? 0 : q + 1;
		end
	endtask
	task automatic used(input int n);
		repeat (n) begin
			desc_used <= 1'b1;
			@(posedge pclk);
			desc_used <= 1'b0;
			@(posedge pclk);
		end
	endtask
	function automatic logic [10:0] exp_split(logic [3:0] p, logic v4, logic v6);
		logic fr;
		fr = p inside {4'h1, 4'h2, 4'h7, 4'h8} ? v4 : p inside {4'h5, 4'h6, 4'hb, 4'hc} ? v6 : v4 | v6;
		if (p == 4'h0 || (p inside {4'h1, 4'h3, 4'h5} && !fr))
			return 11'h0;
		return {1'b1, fr ? l3 : p inside {4'h2, 4'h4, 4'h6} ? l4 : l5};
	endfunction

	// ==========================================================
	// scenarios
	task automatic t_regs();
		apb(1'b0, ring_len_off, 32'h0);
		check(r, {24'h0, ring_len_rst});
		apb(1'b0, status_off, 32'h0);
		check(r & 32'h007fffff, 32'h0);
		apb(1'b1, 8'h24, 32'hffffffff);
		check(32'(e), 32'h1);
		apb(1'b0, 8'h24, 32'h0);
		check(32'(e), 32'h1);
		check(r, 32'h0);
	endtask
	task automatic t_split();
		logic [10:0] x;
		logic [31:0] cfg [3] = '{32'h206, 32'h20b, 32'h205};
		for (int p = 0; p < 13; p++) begin
			for (int f = 0; f < 3; f++) begin
				apb(1'b1, ctrl_off, 32'h7 | (32'(p) << 8));
				apb(1'b1, parse_in_off, {f == 2, f == 1, l5, l4, l3});
				apb(1'b0, parse_out_off, 32'h0);
				x = exp_split(4'(p), f == 1, f == 2);
				check(r & (x[10] ? 32'h83ff : 32'h8000), {16'h0, x[10], 5'h0, x[9:0]});
				check((r >> 10) & 32'hf, 32'(p));
			end
		end
		apb(1'b1, parse_in_off, {2'b00, l5, l4, l3});
		foreach (cfg[i]) begin
			apb(1'b1, ctrl_off, cfg[i]);
			apb(1'b0, parse_out_off, 32'h0);
			check(r & 32'h83ff, 32'h0);
			check((r >> 10) & 32'hf, cfg[i][1] ? 32'h2 : 32'h0);
		end
	endtask
	task automatic t_fetch();
		apb(1'b1, thresh_off, 32'h00040208);
		other_pending <= 1'b1;
		delay <= 4'h5;
		apb(1'b1, tail_off, 32'h8);
		wait_idle();
		apb(1'b0, status_off, 32'h0);
		check(r & 32'h7fff, 32'h0808);
		check(32'(fetch_end), 32'h8);
		delay <= 4'h0;
		apb(1'b1, tail_off, 32'ha);
		wait_idle();
		apb(1'b0, status_off, 32'h0);
		check(r & 32'h7fff, 32'h0808);
		other_pending <= 1'b0;
		wait_idle();
		apb(1'b0, status_off, 32'h0);
		check(r & 32'h7fff, 32'h0a0a);
		check(32'(fetch_end), 32'ha);
	endtask
	task automatic t_wback();
		used(3);
		wait_idle();
		check(32'(last_wb), 32'h0);
		used(1);
		wait_idle();
		check(32'({last_wb.index, last_wb.count}), 32'h0004);
		check(32'(irq_cnt), 32'h0);
		apb(1'b0, status_off, 32'h0);
		check(r & 32'h007f0000, 32'h0);
		used(2);
		apb(1'b1, delay_off, 32'h80000000);
		wait_idle();
		check(32'({last_wb.index, last_wb.count}), 32'h0202);
		check(32'(irq_cnt), 32'h1);
		used(1);
		timer_expired <= 1'b1;
		@(posedge pclk);
		timer_expired <= 1'b0;
		wait_idle();
		check(32'({last_wb.index, last_wb.count}), 32'h0301);
		check(32'(irq_cnt), 32'h2);
	endtask

	// ==========================================================
	// clock, reset, watchdog
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (rx_interrupt === 1'b1)
			irq_cnt++;
	end
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			finish_test();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, desc_used, timer_expired, other_pending} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		delay = 4'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_split();
		t_fetch();
		t_wback();
		finish_test();
	end
endmodule
